// >>> logic/aeu_pkg.sv
// constants and types shared by the address error exception unit
package aeu_pkg;
    // bus address width and register offsets
    localparam int ADDR_W = 24;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ERR_ADDR = 12'h008;
    localparam logic [11:0] REG_CAUSE = 12'h00C;
    localparam logic [11:0] REG_SRC_CNT = 12'h010;
    // control register fields and reset value
    localparam int CTRL_SINGLE_BIT = 0;
    localparam int CTRL_MODE2_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // cause register bit positions
    localparam int CAUSE_FETCH = 0;
    localparam int CAUSE_STACK = 1;
    localparam int CAUSE_CPU_DATA = 2;
    localparam int CAUSE_DMA_DATA = 3;
    localparam int CAUSE_DMA_SINGLE = 4;
    localparam int CAUSE_W = 5;
    // address map defaults
    localparam logic [23:0] EXT_LO = 24'h100000;
    localparam logic [23:0] EXT_HI = 24'hFEFFFF;
    localparam logic [23:0] RSV_LO = 24'hFF0000;
    localparam logic [23:0] RSV_HI = 24'hFFBFFF;
    localparam logic [23:0] WIN_LO = 24'hFF8000;
    localparam logic [23:0] WIN_HI = 24'hFF8FFF;
    localparam logic [23:0] PERIPH_LO = 24'hFFC000;
    localparam logic [23:0] PERIPH_HI = 24'hFFFFFF;
    // bus cycle kinds reported by the core
    localparam logic [1:0] CYC_FETCH = 2'h0;
    localparam logic [1:0] CYC_STACK = 2'h1;
    localparam logic [1:0] CYC_DATA = 2'h2;
    // status bit positions
    localparam int CCR_I_BIT = 7;
    localparam int EXR_T_BIT = 7;
    localparam int EXR_PRI_LSB = 0;
    localparam logic [2:0] PRI_MASK_ALL = 3'h7;
    // vector offsets and stacking offsets
    localparam logic [23:0] VEC_OFS_CPU = 24'h000030;
    localparam logic [23:0] VEC_OFS_DMA = 24'h000034;
    localparam logic [23:0] STK_PC_OFS = 24'h000004;
    localparam logic [23:0] STK_SR_OFS = 24'h000008;
    localparam logic [3:0] EXC_LEVEL = 4'h8;
    // interrupt source counts
    localparam logic [3:0] SRC_NMI = 4'h1;
    localparam logic [3:0] SRC_IRQ = 4'hF;
    localparam logic [3:0] SRC_SSU = 4'h9;
    localparam logic [3:0] SRC_DMA = 4'h8;
    localparam logic [3:0] SRC_SCI = 4'h8;
    localparam logic [7:0] SRC_TPU_BIG = 8'h34;
    localparam logic [7:0] SRC_TPU_SMALL = 8'h1A;
    // exception sequencer states
    typedef enum logic [1:0] {AEU_IDLE, AEU_PUSH_PC, AEU_PUSH_SR, AEU_VEC_RD} aeu_seq_t;
endpackage

// >>> logic/aeu_core.sv
// address error detector and exception sequencer with apb control registers
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module aeu_core
    import aeu_pkg::*;
#(
    parameter int DMA_CH = 4,
    parameter bit BIG_VARIANT = 1'b1,
    parameter logic [23:0] EXT_BASE = EXT_LO,
    parameter logic [23:0] EXT_LIMIT = EXT_HI,
    parameter logic [23:0] RSV_BASE = RSV_LO,
    parameter logic [23:0] RSV_LIMIT = RSV_HI,
    parameter logic [23:0] PERIPH_BASE = PERIPH_LO,
    parameter logic [23:0] PERIPH_LIMIT = PERIPH_HI
)
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // cpu bus cycle report
    input wire logic cpu_cyc_valid_in,
    input wire logic [1:0] cpu_cyc_kind_in,
    input wire logic [ADDR_W-1:0] cpu_cyc_addr_in,
    input wire logic cpu_insn_done_in,
    // cpu context
    input wire logic [31:0] cpu_pc_in,
    input wire logic [ADDR_W-1:0] cpu_sp_in,
    input wire logic [7:0] cpu_ccr_in,
    input wire logic [7:0] cpu_exr_in,
    input wire logic [ADDR_W-1:0] cpu_vbr_in,
    // dma bus cycle report
    input wire logic dma_cyc_valid_in,
    input wire logic dma_single_in,
    input wire logic [ADDR_W-1:0] dma_cyc_addr_in,
    // exception memory port
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_rdata_in,
    // cpu state updates
    output logic exc_busy_out,
    output logic [3:0] exc_level_out,
    output logic [7:0] ccr_out,
    output logic [7:0] exr_out,
    output logic flags_load_out,
    output logic [31:0] pc_out,
    output logic pc_load_out,
    // dma controller halt
    output logic dma_fault_set_out,
    output logic [DMA_CH-1:0] dma_te_clear_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        aeu_seq_t state;
        logic pend;
        logic pend_dma;
        logic [ADDR_W-1:0] err_addr;
        logic [1:0] ctrl;
        logic [CAUSE_W-1:0] cause;
        logic [31:0] sv_pc;
        logic [ADDR_W-1:0] sv_sp;
        logic [7:0] sv_ccr;
        logic [7:0] sv_exr;
        logic cur_dma;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic mem_req;
        logic mem_we;
        logic [ADDR_W-1:0] mem_addr;
        logic [31:0] mem_wdata;
        logic busy;
        logic [3:0] level;
        logic [7:0] condition_code_reg;
        logic [7:0] extended_control_reg;
        logic flags_load;
        logic [31:0] pc;
        logic pc_load;
        logic fault_set;
        logic [DMA_CH-1:0] te_clear;
    } aeu_state_t;

    aeu_state_t q;
    aeu_state_t d;

    function automatic logic in_rng(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // detection

    logic single_chip;
    logic c_ext;
    logic c_rsv;
    logic c_periph;
    logic d_ext;
    logic d_rsv;
    logic fetch_err;
    logic stack_err;
    logic cdata_err;
    logic ddata_err;
    logic dsingle_err;
    logic cpu_err;
    logic dma_err;
    logic any_err;
    logic take_err;

    assign single_chip = q.ctrl[CTRL_SINGLE_BIT];
    assign c_ext = in_rng(cpu_cyc_addr_in, EXT_BASE, EXT_LIMIT);
    assign d_ext = in_rng(dma_cyc_addr_in, EXT_BASE, EXT_LIMIT);
    assign c_periph = in_rng(cpu_cyc_addr_in, PERIPH_BASE, PERIPH_LIMIT);
    // the window inside the reserved range is carved out
    assign c_rsv = in_rng(cpu_cyc_addr_in, RSV_BASE, RSV_LIMIT)
        && !in_rng(cpu_cyc_addr_in, WIN_LO, WIN_HI);
    assign d_rsv = in_rng(dma_cyc_addr_in, RSV_BASE, RSV_LIMIT)
        && !in_rng(dma_cyc_addr_in, WIN_LO, WIN_HI);

    assign fetch_err = cpu_cyc_valid_in && (cpu_cyc_kind_in == CYC_FETCH)
        && (cpu_cyc_addr_in[0]
        || c_periph
        || (single_chip && c_ext)
        || c_rsv);
    assign stack_err = cpu_cyc_valid_in && (cpu_cyc_kind_in == CYC_STACK)
        && cpu_cyc_addr_in[0];
    // odd word data is legal, so address bit 0 is not looked at here
    assign cdata_err = cpu_cyc_valid_in && (cpu_cyc_kind_in == CYC_DATA)
        && ((single_chip && c_ext) || c_rsv);
    assign ddata_err = dma_cyc_valid_in && !dma_single_in
        && ((single_chip && d_ext) || d_rsv);
    assign dsingle_err = dma_cyc_valid_in && dma_single_in && !d_ext;
    assign cpu_err = fetch_err || stack_err || cdata_err;
    assign dma_err = ddata_err || dsingle_err;
    assign any_err = cpu_err || dma_err;
    // nothing is taken while the sequence runs, which stops stacking loops
    assign take_err = any_err && (q.state == AEU_IDLE) && !q.pend;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic apb_wr;
    logic [CAUSE_W-1:0] cause_set;
    logic [CAUSE_W-1:0] cause_clr;

    assign apb_wr = psel_in && penable_in && q.pready && pwrite_in;
    assign cause_set = {dsingle_err, ddata_err, cdata_err, stack_err, fetch_err};
    assign cause_clr = (apb_wr && (paddr_in == REG_CAUSE)) ? pwdata_in[CAUSE_W-1:0]
        : {CAUSE_W{1'b0}};

    always_comb
    begin
        d = q;
        d.flags_load = 1'b0;
        d.pc_load = 1'b0;
        d.fault_set = 1'b0;
        d.te_clear = '0;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        d.prdata = 32'h00000000;
        // apb setup phase prepares the answer shown in the access phase
        if (psel_in && !penable_in)
        begin
            d.pready = 1'b1;
            if (paddr_in == REG_CTRL)
            begin
                d.prdata = {30'h00000000, q.ctrl};
            end
            else if (paddr_in == REG_STATUS)
            begin
                d.prdata = {24'h000000, q.level, q.state, q.pend_dma, q.pend};
            end
            else if (paddr_in == REG_ERR_ADDR)
            begin
                d.prdata = {8'h00, q.err_addr};
            end
            else if (paddr_in == REG_CAUSE)
            begin
                d.prdata = {27'h0000000, q.cause};
            end
            else if (paddr_in == REG_SRC_CNT)
            begin
                d.prdata = {4'h0, BIG_VARIANT ? SRC_TPU_BIG : SRC_TPU_SMALL, SRC_SCI,
                    SRC_DMA, SRC_SSU, SRC_IRQ, SRC_NMI};
            end
            else
            begin
                d.pslverr = 1'b1;
            end
        end
        if (apb_wr && (paddr_in == REG_CTRL))
        begin
            d.ctrl = pwdata_in[1:0];
        end
        // a new cause beats a clear in the same cycle
        d.cause = (q.cause & ~cause_clr) | cause_set;
        // sequencer
        case (q.state)
            AEU_IDLE:
            begin
                // held until the core reports the instruction boundary
                if (q.pend && cpu_insn_done_in)
                begin
                    d.pend = 1'b0;
                    d.cur_dma = q.pend_dma;
                    d.sv_pc = cpu_pc_in;
                    d.sv_sp = cpu_sp_in;
                    d.sv_ccr = cpu_ccr_in;
                    d.sv_exr = cpu_exr_in;
                    d.busy = 1'b1;
                    d.level = EXC_LEVEL;
                    // an odd pointer is used as is; the stacked words are then undefined
                    d.mem_req = 1'b1;
                    d.mem_we = 1'b1;
                    d.mem_addr = cpu_sp_in - STK_PC_OFS;
                    d.mem_wdata = cpu_pc_in;
                    d.state = AEU_PUSH_PC;
                end
            end
            AEU_PUSH_PC:
            begin
                if (mem_ack_in)
                begin
                    d.mem_addr = q.sv_sp - STK_SR_OFS;
                    d.mem_wdata = {16'h0000, q.sv_ccr, q.sv_exr};
                    d.state = AEU_PUSH_SR;
                end
            end
            AEU_PUSH_SR:
            begin
                if (mem_ack_in)
                begin
                    d.condition_code_reg = q.sv_ccr;
                    d.extended_control_reg = q.sv_exr;
                    d.condition_code_reg[CCR_I_BIT] = 1'b1;
                    if (q.ctrl[CTRL_MODE2_BIT])
                    begin
                        d.extended_control_reg[EXR_T_BIT] = 1'b0;
                        d.extended_control_reg[EXR_PRI_LSB +: 3] = PRI_MASK_ALL;
                    end
                    d.flags_load = 1'b1;
                    d.mem_we = 1'b0;
                    // the cpu entry ignores the base register, the dma entry adds it
                    d.mem_addr = q.cur_dma ? (cpu_vbr_in + VEC_OFS_DMA)
                        : VEC_OFS_CPU;
                    d.mem_wdata = 32'h00000000;
                    d.state = AEU_VEC_RD;
                end
            end
            AEU_VEC_RD:
            begin
                if (mem_ack_in)
                begin
                    d.mem_req = 1'b0;
                    d.pc = mem_rdata_in;
                    d.pc_load = 1'b1;
                    d.busy = 1'b0;
                    d.level = 4'h0;
                    d.state = AEU_IDLE;
                end
            end
            default:
            begin
                d.state = AEU_IDLE;
            end
        endcase
        // first error wins; cpu beats dma in the same cycle
        if (take_err)
        begin
            d.pend = 1'b1;
            d.pend_dma = !cpu_err;
            d.err_addr = cpu_err ? cpu_cyc_addr_in : dma_cyc_addr_in;
            d.fault_set = 1'b1;
            d.te_clear = {DMA_CH{1'b1}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q <= '0;
            q.state <= AEU_IDLE;
            q.ctrl <= CTRL_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata_out = q.prdata;
    assign pready_out = q.pready;
    assign pslverr_out = q.pslverr;
    assign mem_req_out = q.mem_req;
    assign mem_we_out = q.mem_we;
    assign mem_addr_out = q.mem_addr;
    assign mem_wdata_out = q.mem_wdata;
    assign exc_busy_out = q.busy;
    assign exc_level_out = q.level;
    assign ccr_out = q.condition_code_reg;
    assign exr_out = q.extended_control_reg;
    assign flags_load_out = q.flags_load;
    assign pc_out = q.pc;
    assign pc_load_out = q.pc_load;
    assign dma_fault_set_out = q.fault_set;
    assign dma_te_clear_out = q.te_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_odd_fetch_pend: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (cpu_cyc_valid_in && cpu_cyc_kind_in == CYC_FETCH && cpu_cyc_addr_in[0]
        && q.state == AEU_IDLE && !q.pend) |=> (q.pend && !q.pend_dma))
        else $error("odd fetch did not leave a cpu error pending");

    a_odd_stack_pend: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (cpu_cyc_valid_in && cpu_cyc_kind_in == CYC_STACK && cpu_cyc_addr_in[0]
        && q.state == AEU_IDLE && !q.pend) |=> q.pend)
        else $error("odd stack access not flagged");

    a_window_is_free: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (dma_cyc_valid_in && !dma_single_in && in_rng(dma_cyc_addr_in, WIN_LO, WIN_HI)
        && !(single_chip && d_ext)) |-> !dma_err)
        else $error("window access flagged as error");

    a_odd_word_ok: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (cpu_cyc_valid_in && cpu_cyc_kind_in == CYC_DATA && !c_rsv && !c_ext) |-> !cpu_err)
        else $error("plain data access flagged as error");

    a_busy_no_take: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (q.state != AEU_IDLE) |=> !$rose(q.pend))
        else $error("error taken during exception entry");

    a_entry_boundary: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(q.busy) |-> ($past(cpu_insn_done_in) && $past(q.pend)))
        else $error("exception entered off an instruction boundary");

    a_dma_halted: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        take_err |=> (dma_fault_set_out && (&dma_te_clear_out)))
        else $error("dma not halted after address error");

    a_mode2_flags: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (flags_load_out && q.ctrl[CTRL_MODE2_BIT]) |-> (ccr_out[CCR_I_BIT]
        && !exr_out[EXR_T_BIT] && exr_out[EXR_PRI_LSB +: 3] == PRI_MASK_ALL))
        else $error("mode 2 flags wrong after entry");

    a_cpu_vector: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (q.state == AEU_VEC_RD && !q.cur_dma) |-> (mem_addr_out == VEC_OFS_CPU && !mem_we_out))
        else $error("cpu vector address not the bare offset");

    a_level_eight: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        exc_busy_out |-> (exc_level_out == EXC_LEVEL))
        else $error("exception level is not 8");

    a_push_order: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (q.state == AEU_PUSH_PC && mem_ack_in) |=> (q.state == AEU_PUSH_SR
        && mem_addr_out == q.sv_sp - STK_SR_OFS && mem_we_out))
        else $error("status not pushed after program counter");

endmodule // aeu_core

`default_nettype wire

// >>> testbench/aeu_mem_model.sv
// memory responder for the stacking and vector cycles of exception entry
`timescale 1ns/1ps
`default_nettype none
module aeu_mem_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // request side
    input wire logic req_in,
    input wire logic [23:0] addr_in,
    input wire logic slow_in,
    // answer side
    output logic ack_out,
    output logic [31:0] rdata_out
);
    logic [1:0] wait_q;
    // data valid only with ack; inverted otherwise so a stale read shows up
    assign rdata_out = ack_out ? {8'hA5, addr_in} : ~{8'hA5, addr_in};
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ack_out <= 1'b0;
            wait_q <= 2'h0;
        end
        else if (req_in && !ack_out && wait_q == 2'h0)
        begin
            ack_out <= 1'b1;
            wait_q <= slow_in ? 2'h3 : 2'h0;
        end
        else
        begin
            ack_out <= 1'b0;
            if (wait_q != 2'h0)
                wait_q <= wait_q - 2'h1;
        end
    end
endmodule // aeu_mem_model
`default_nettype wire

// >>> testbench/aeu_core_test.sv
// self-checking bench for the address error exception unit
`timescale 1ns/1ps
`default_nettype none
module aeu_core_test;
    import aeu_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwd = 32'h0, prd, pc = 32'h0, pco, mwd, mrd;
    logic prdy, perr, cv = 1'b0, idone = 1'b0, dv = 1'b0, ds = 1'b0, slow = 1'b0;
    logic [1:0] ck = 2'h0;
    logic [23:0] ca = 24'h0, sp = 24'h0, vector_base_reg = 24'h0, da = 24'h0, maddr;
    logic [7:0] condition_code_reg = 8'h0, extended_control_reg = 8'h0, ccr_o, exr_o;
    logic mreq, mwe, mack, busy, fload, pload, fset, m2;
    logic [3:0] lvl, te;
    logic [32:0] t;
    logic [31:0] rs = 32'h22B9DAD0, r, r2, r3;
    logic [32:0] q_rd [$];
    logic [63:0] q_ex [$];
    int failures = 0, n_checks = 0, n_fault = 0, exp_fault = 0;
    // dma, kind or single, single-chip, address, expected cause bits
    localparam logic [32:0] TBL [19] = '{
        {3'h0, 1'h0, 24'h000101, 5'h01}, {3'h0, 1'h0, 24'h000100, 5'h00},
        {3'h0, 1'h0, 24'hFFC000, 5'h01},
        {3'h0, 1'h1, 24'h100000, 5'h01}, {3'h0, 1'h0, 24'h100000, 5'h00},
        {3'h0, 1'h0, 24'hFF0000, 5'h01},
        {3'h0, 1'h0, 24'hFF8000, 5'h00}, {3'h2, 1'h0, 24'hFF8FFE, 5'h00},
        {3'h4, 1'h0, 24'hFF8FFE, 5'h00},
        {3'h1, 1'h0, 24'h000FF1, 5'h02}, {3'h1, 1'h0, 24'h000FF0, 5'h00},
        {3'h2, 1'h1, 24'h000101, 5'h00}, {3'h4, 1'h0, 24'h000101, 5'h00},
        {3'h2, 1'h1, 24'h100000, 5'h04}, {3'h4, 1'h1, 24'h100001, 5'h08},
        {3'h2, 1'h0, 24'hFF0002, 5'h04}, {3'h4, 1'h0, 24'hFF0000, 5'h08},
        {3'h5, 1'h0, 24'h000200, 5'h10}, {3'h5, 1'h0, 24'h100000, 5'h00}};
    ////////////////////////////////////////////////////////////////////////
    aeu_core uut (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .cpu_cyc_valid_in(cv), .cpu_cyc_kind_in(ck),
        .cpu_cyc_addr_in(ca), .cpu_insn_done_in(idone), .cpu_pc_in(pc), .cpu_sp_in(sp),
        .cpu_ccr_in(condition_code_reg), .cpu_exr_in(extended_control_reg), .cpu_vbr_in(vector_base_reg), .dma_cyc_valid_in(dv),
        .dma_single_in(ds), .dma_cyc_addr_in(da), .mem_req_out(mreq), .mem_we_out(mwe),
        .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_ack_in(mack), .mem_rdata_in(mrd),
        .exc_busy_out(busy), .exc_level_out(lvl), .ccr_out(ccr_o), .exr_out(exr_o),
        .flags_load_out(fload), .pc_out(pco), .pc_load_out(pload),
        .dma_fault_set_out(fset), .dma_te_clear_out(te));
    aeu_mem_model mem (.clk_in(clk), .rst_n_in(rst_n), .req_in(mreq), .addr_in(maddr),
        .slow_in(slow), .ack_out(mack), .rdata_out(mrd));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t apb read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_exc(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t exception result %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for apb ready or for the handler load
    task automatic wait_on(input bit use_pc);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!(use_pc ? pload : prdy) && n < 60);
        if ((use_pc ? pload : prdy) !== 1'b1)
        begin
            failures++;
            close_out();
        end
    endtask
    // request held from setup until the edge that samples ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge clk);
        if (!w)
            q_rd.push_back(e);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        wait_on(1'b0);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (psel && pen && prdy && !pwr)
            chk_bus({perr, prd}, q_rd.pop_front());
        if (fload)
            chk_exc({48'h0, ccr_o, exr_o}, q_ex.pop_front());
        else if (pload)
            chk_exc({32'h0, pco}, q_ex.pop_front());
        else if (mreq && mack && mwe)
            chk_exc({lvl, 4'h0, maddr, mwd}, q_ex.pop_front());
        if (fset && te === 4'hF)
            n_fault++;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0, 33'h0);
        apb(1'b0, REG_SRC_CNT, 32'h0, {5'h0, 8'h34, 20'h889F1});
        apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
        for (int i = 0; i < 19; i++)
        begin
            t = TBL[i];
            m2 = i[1];
            apb(1'b1, REG_CTRL, {30'h0, m2, t[29]}, 33'h0);
            r = rnd();
            r2 = rnd();
            r3 = rnd();
            pc <= rnd();
            condition_code_reg <= r[7:0];
            extended_control_reg <= r[15:8];
            sp <= {r2[23:1], 1'b0};
            vector_base_reg <= r3[23:0];
            slow <= r[16];
            cv <= !t[32];
            ck <= t[31:30];
            ca <= t[28:5];
            dv <= t[32];
            ds <= t[30];
            da <= t[28:5];
            @(posedge clk);
            cv <= 1'b0;
            dv <= 1'b0;
            if (|t[4:0])
            begin
                exp_fault++;
                q_ex.push_back({8'h80, sp - 24'h4, pc});
                q_ex.push_back({8'h80, sp - 24'h8, 16'h0, condition_code_reg, extended_control_reg});
                q_ex.push_back({48'h0, condition_code_reg | 8'h80, m2 ? {1'b0, extended_control_reg[6:3], 3'h7} : extended_control_reg});
                q_ex.push_back({32'h0, 8'hA5, t[32] ? vector_base_reg + 24'h34 : 24'h30});
                // pending with its master while the core has not reached a boundary
                apb(1'b0, REG_STATUS, 32'h0, {1'b0, 24'h0, 4'h0, 2'h0, t[32], 1'b1});
                chk_exc({63'h0, busy}, 64'h0);
                idone <= 1'b1;
                @(posedge clk);
                idone <= 1'b0;
                // after a dma error, a fresh cpu fetch error during entry must not start a second sequence
                cv <= t[32];
                ck <= 2'h0;
                ca <= 24'h000001;
                @(posedge clk);
                cv <= 1'b0;
                wait_on(1'b1);
                apb(1'b0, REG_ERR_ADDR, 32'h0, {9'h0, t[28:5]});
            end
            apb(1'b0, REG_CAUSE, 32'h0, {28'h0, t[4:0] | {4'h0, t[32] & |t[4:0]}});
            apb(1'b1, REG_CAUSE, 32'h1F, 33'h0);
            chk_exc(64'(n_fault), 64'(exp_fault));
        end
        close_out();
    end
endmodule // aeu_core_test
`default_nettype wire
